// ==== sirqc_pkg.sv ====
// Shared constants, types and decoders of the serial interrupt stream controller
package sirqc_pkg;

	localparam int unsigned ADDR_W    = 14;
	localparam int unsigned IRQ_LINES = 16;
	localparam int unsigned SLOT_W    = 5;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_MODE     = 12'h0E0;
	localparam logic [11:0] IDX_TRIG     = 12'h0E2;
	localparam logic [11:0] IDX_STAT     = 12'h0E4;
	localparam logic [11:0] IDX_EVT_STAT = 12'h0F0;
	localparam logic [11:0] IDX_EVT_EN   = 12'h0F1;
	localparam logic [11:0] IDX_EVT_CLR  = 12'h0F2;

	// One-hot select positions
	localparam int unsigned SEL_MODE = 0;
	localparam int unsigned SEL_TRIG = 1;
	localparam int unsigned SEL_STAT = 2;
	localparam int unsigned SEL_EVTS = 3;
	localparam int unsigned SEL_EVTE = 4;
	localparam int unsigned SEL_EVTC = 5;
	localparam int unsigned SEL_N    = 6;

	// Mode control fields
	localparam int unsigned MODE_DRIVE_BIT = 0;
	localparam int unsigned MODE_POLL_BIT  = 1;
	localparam int unsigned MODE_WID_LSB   = 2;
	localparam int unsigned MODE_RSVD_LSB  = 4;
	localparam logic [7:0]  MODE_RESET     = 8'h00;
	localparam logic [15:0] LINE_RESET     = 16'h0000;

	// Frame timing in bus clocks
	localparam logic [1:0] WID_CODE_6   = 2'h1;
	localparam logic [1:0] WID_CODE_8   = 2'h2;
	localparam logic [3:0] START_CLK_4  = 4'h4;
	localparam logic [3:0] START_CLK_6  = 4'h6;
	localparam logic [3:0] START_CLK_8  = 4'h8;
	localparam logic [3:0] STOP_CLK_QT  = 4'h2;
	localparam logic [3:0] STOP_CLK_CT  = 4'h3;
	localparam logic [1:0] PH_SAMPLE    = 2'h0;
	localparam logic [1:0] PH_TURN      = 2'h2;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h14;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_START = 8'h02,
		ST_SREC  = 8'h04,
		ST_STURN = 8'h08,
		ST_SLOT  = 8'h10,
		ST_STOP  = 8'h20,
		ST_PREC  = 8'h40,
		ST_PTURN = 8'h80
	} sirqc_state_t;

	function automatic logic [3:0] start_clocks(input logic [1:0] code);
		// Reserved code falls back to the shortest width
		return (code == WID_CODE_6) ? START_CLK_6 :
		       (code == WID_CODE_8) ? START_CLK_8 : START_CLK_4;
	endfunction : start_clocks

	function automatic logic [SEL_N-1:0] reg_sel(input logic [ADDR_W-1:0] a);
		reg_sel = '0;
		reg_sel[SEL_MODE] = (a == {IDX_MODE, 2'h0});
		reg_sel[SEL_TRIG] = (a == {IDX_TRIG, 2'h0});
		reg_sel[SEL_STAT] = (a == {IDX_STAT, 2'h0});
		reg_sel[SEL_EVTS] = (a == {IDX_EVT_STAT, 2'h0});
		reg_sel[SEL_EVTE] = (a == {IDX_EVT_EN, 2'h0});
		reg_sel[SEL_EVTC] = (a == {IDX_EVT_CLR, 2'h0});
	endfunction : reg_sel

endpackage : sirqc_pkg

// ==== sirqc_frame.sv ====
// Serial interrupt stream frame sequencer
`timescale 1ns/1ps
module sirqc_frame (
	input  wire logic                      clk_i,       // Bus clock
	input  wire logic                      rst_i,       // Sync reset, high
	input  wire logic [1:0]                width_i,     // Start width code
	input  wire logic                      quiet_i,     // Quiet polling
	input  wire logic                      float_i,     // Float in recovery
	input  wire logic                      sirq_i,      // Line level
	output logic                           sirq_o,      // Line drive value
	output logic                           sirq_oe_o,   // Line drive enable
	output logic                           smp_valid_o, // Slot sampled
	output logic [sirqc_pkg::SLOT_W-1:0]   smp_slot_o,  // Sampled slot
	output logic                           smp_act_o    // Slot was low
);
	import sirqc_pkg::*;

	sirqc_state_t      state_ff, nxt_state;
	logic [3:0]        cnt_ff, nxt_cnt;
	logic [1:0]        phase_ff, nxt_phase;
	logic [SLOT_W-1:0] slot_ff, nxt_slot;
	logic [3:0]        drv_cnt_ff;
	logic [3:0]        len_ff;
	logic              agent_ff;

	wire [3:0] start_len = start_clocks(width_i);
	wire [3:0] stop_len  = quiet_i ? STOP_CLK_QT : STOP_CLK_CT;
	wire       in_rec    = (state_ff == ST_SREC) || (state_ff == ST_PREC);
	wire       in_low    = (state_ff == ST_START) || (state_ff == ST_STOP);
	// Lengths latched on entry so a mid-frame mode write cannot cut a pulse
	wire       start_in  = (nxt_state == ST_START) && (state_ff != ST_START);
	wire       stop_in   = (nxt_state == ST_STOP) && (state_ff != ST_STOP);
	wire [3:0] nxt_len   = start_in ? start_len : (stop_in ? stop_len : len_ff);

	assign sirq_oe_o = in_low || (in_rec && !float_i);
	assign sirq_o    = in_rec;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + 4'h1;
		nxt_phase = PH_SAMPLE;
		nxt_slot  = slot_ff;
		unique case (state_ff)
			ST_IDLE: begin
				nxt_cnt = 4'h0;
				if (!quiet_i) begin
					nxt_state = ST_START;
				end else if (!sirq_i) begin
					nxt_state = ST_START;
					nxt_cnt   = 4'h1;
				end
			end
			ST_START: if (cnt_ff == len_ff - 4'h1) nxt_state = ST_SREC;
			ST_SREC:  nxt_state = ST_STURN;
			ST_STURN: nxt_slot = '0;
			ST_SLOT: begin
				nxt_phase = phase_ff + 2'h1;
				nxt_cnt   = 4'h0;
				if (phase_ff == PH_TURN) begin
					nxt_phase = PH_SAMPLE;
					nxt_slot  = slot_ff + 5'h1;
					if (slot_ff == SLOT_LAST) nxt_state = ST_STOP;
				end
			end
			ST_STOP:  if (cnt_ff == len_ff - 4'h1) nxt_state = ST_PREC;
			ST_PREC:  nxt_state = ST_PTURN;
			ST_PTURN: begin
				nxt_cnt   = 4'h0;
				nxt_state = quiet_i ? ST_IDLE : ST_START;
			end
		endcase
		if (state_ff == ST_STURN) nxt_state = ST_SLOT;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 4'h0;
			phase_ff <= PH_SAMPLE;
			slot_ff  <= '0;
			len_ff   <= START_CLK_4;
		end else begin
			state_ff <= nxt_state;
			len_ff   <= nxt_len;
			cnt_ff   <= nxt_cnt;
			phase_ff <= nxt_phase;
			slot_ff  <= nxt_slot;
		end
	end

	// Agents drive their slot low in the sample phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smp_valid_o <= 1'b0;
			smp_slot_o  <= '0;
			smp_act_o   <= 1'b0;
		end else begin
			smp_valid_o <= (state_ff == ST_SLOT) && (phase_ff == PH_SAMPLE);
			smp_slot_o  <= slot_ff;
			smp_act_o   <= !sirq_i;
		end
	end

	// Helper: length of host-driven start pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_cnt_ff <= 4'h0;
			agent_ff   <= 1'b0;
		end else begin
			drv_cnt_ff <= (state_ff == ST_START) ? drv_cnt_ff + 4'h1 : 4'h0;
			if (state_ff == ST_IDLE) begin
				agent_ff <= quiet_i && !sirq_i;
			end else if (state_ff == ST_PTURN) begin
				agent_ff <= 1'b0;
			end
		end
	end

	a_start_width_len: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_ff == ST_SREC) |-> (drv_cnt_ff + {3'h0, agent_ff}) == len_ff)
		else $error("start frame width wrong");

	a_cont_restart_now: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_PTURN) && !quiet_i |=> sirq_oe_o && !sirq_o)
		else $error("continuous mode did not restart");

	a_quiet_stays_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_PTURN) && quiet_i |=> !sirq_oe_o && (state_ff == ST_IDLE))
		else $error("quiet mode started a frame");

	a_recovery_drive_sel: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(in_rec) |-> sirq_o && (sirq_oe_o == !float_i) ##1 !sirq_oe_o)
		else $error("recovery cycle drive wrong");

	a_slot_count_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_ff == ST_SLOT) |-> ##62 (state_ff == ST_SLOT) ##1 (state_ff == ST_STOP))
		else $error("slot count wrong");

	a_quiet_stop_len: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_ff == ST_STOP) && $past(quiet_i) |-> sirq_oe_o [*2] ##1 sirq_o)
		else $error("quiet stop frame length wrong");

	c_quiet_start: cover property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_IDLE) && quiet_i && !sirq_i ##1 (state_ff == ST_START));

	c_cont_frame: cover property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == ST_PTURN) && !quiet_i ##1 (state_ff == ST_START));

endmodule : sirqc_frame

// ==== sirqc_top.sv ====
// Serial interrupt stream controller with AXI4-Lite register slave
//
// Functional notes
// - Start frame lasts 4, 6 or 8 clocks for width codes 0, 1, 2.
// - Polling bit 0 runs continuous frames; 1 runs quiet, agent-started frames.
// - Recovery cycle drives high when drive bit is 0, floats when 1.
// - Upper four bits of the mode control byte always read zero.
// - Any reset clears mode, trigger type and status bits.
// - Trigger bit 0 makes a line edge triggered, 1 makes it level triggered.
// - Level line seen active in its slot sets its status bit.
// - Writing one clears a status bit and re-arms it; zero does nothing.
// - Edge-mode lines never set a status bit.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sirqc_top (
	input  wire logic                          CLOCK_I,              // Bus clock
	input  wire logic                          RESETN_I,             // Sync reset
	input  wire logic                          GLOBAL_RESET_PIN_N_I, // Global reset
	input  wire logic [sirqc_pkg::ADDR_W-1:0]  S_AXI_AWADDR,         // Write address
	input  wire logic                          S_AXI_AWVALID,        // Address valid
	output logic                               S_AXI_AWREADY,        // Address ready
	input  wire logic [31:0]                   S_AXI_WDATA,          // Write data
	input  wire logic [3:0]                    S_AXI_WSTRB,          // Byte strobes
	input  wire logic                          S_AXI_WVALID,         // Data valid
	output logic                               S_AXI_WREADY,         // Data ready
	output logic [1:0]                         S_AXI_BRESP,          // Write response
	output logic                               S_AXI_BVALID,         // Response valid
	input  wire logic                          S_AXI_BREADY,         // Response ready
	input  wire logic [sirqc_pkg::ADDR_W-1:0]  S_AXI_ARADDR,         // Read address
	input  wire logic                          S_AXI_ARVALID,        // Address valid
	output logic                               S_AXI_ARREADY,        // Address ready
	output logic [31:0]                        S_AXI_RDATA,          // Read data
	output logic [1:0]                         S_AXI_RRESP,          // Read response
	output logic                               S_AXI_RVALID,         // Read valid
	input  wire logic                          S_AXI_RREADY,         // Read ready
	input  wire logic                          SIRQ_I,               // Line level
	output logic                               SIRQ_O,               // Line drive
	output logic                               SIRQ_OE_O,            // Line enable
	output logic [sirqc_pkg::IRQ_LINES-1:0]    IRQ_FWD_O,            // Upstream pulses
	output logic                               IRQ_O                 // Interrupt
);
	import sirqc_pkg::*;

	logic rst;
	assign rst = !RESETN_I || !GLOBAL_RESET_PIN_N_I;

	// Write channel
	logic              aw_hold_ff;
	logic              w_hold_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;

	assign S_AXI_AWREADY = !aw_hold_ff && !bvalid_ff;
	assign S_AXI_WREADY  = !w_hold_ff && !bvalid_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;

	wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
	wire wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;

	wire [SEL_N-1:0] wsel = reg_sel(awaddr_ff);
	wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
	                     {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire [31:0] wbits = wdata_ff & wmask;

	always_ff @(posedge CLOCK_I) begin
		if (rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= '0;
			wdata_ff   <= 32'h0;
			wstrb_ff   <= 4'h0;
		end else begin
			if (aw_take) awaddr_ff <= S_AXI_AWADDR;
			if (w_take) wdata_ff <= S_AXI_WDATA;
			if (w_take) wstrb_ff <= S_AXI_WSTRB;
			aw_hold_ff <= aw_take || (aw_hold_ff && !wr_fire);
			w_hold_ff  <= w_take || (w_hold_ff && !wr_fire);
			bvalid_ff  <= wr_fire || (bvalid_ff && !S_AXI_BREADY);
			if (wr_fire) bresp_ff <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Register file
	logic [3:0]           mode_ff;
	logic [IRQ_LINES-1:0] trig_ff;
	logic [IRQ_LINES-1:0] stat_ff;
	logic [IRQ_LINES-1:0] prev_act_ff;
	logic [IRQ_LINES-1:0] evt_ff;
	logic [IRQ_LINES-1:0] evt_en_ff;
	logic [IRQ_LINES-1:0] fwd_ff;

	wire we_mode = wr_fire && wsel[SEL_MODE];
	wire we_trig = wr_fire && wsel[SEL_TRIG];
	wire we_stat = wr_fire && wsel[SEL_STAT];
	wire we_evte = wr_fire && wsel[SEL_EVTE];
	wire we_evtc = wr_fire && wsel[SEL_EVTC];

	wire [3:0] nxt_mode = (mode_ff & ~wmask[3:0]) | wbits[3:0];
	wire [IRQ_LINES-1:0] nxt_trig = (trig_ff & ~wmask[15:0]) | wbits[15:0];
	wire [IRQ_LINES-1:0] nxt_evt_en = (evt_en_ff & ~wmask[15:0]) | wbits[15:0];
	wire [IRQ_LINES-1:0] clr_stat = we_stat ? wbits[15:0] : LINE_RESET;
	wire [IRQ_LINES-1:0] clr_evt  = we_evtc ? wbits[15:0] : LINE_RESET;

	// Frame sequencer
	logic              smp_valid;
	logic [SLOT_W-1:0] smp_slot;
	logic              smp_act;

	sirqc_frame u_frame (
		.clk_i       (CLOCK_I),
		.rst_i       (rst),
		.width_i     (mode_ff[MODE_WID_LSB +: 2]),
		.quiet_i     (mode_ff[MODE_POLL_BIT]),
		.float_i     (mode_ff[MODE_DRIVE_BIT]),
		.sirq_i      (SIRQ_I),
		.sirq_o      (SIRQ_O),
		.sirq_oe_o   (SIRQ_OE_O),
		.smp_valid_o (smp_valid),
		.smp_slot_o  (smp_slot),
		.smp_act_o   (smp_act)
	);

	// Per-line trigger handling
	logic [IRQ_LINES-1:0] lvl_hit;
	logic [IRQ_LINES-1:0] edge_hit;
	logic [IRQ_LINES-1:0] line_smp;

	genvar gi;
	generate
		for (gi = 0; gi < IRQ_LINES; gi++) begin : g_line
			assign line_smp[gi] = smp_valid && (smp_slot == SLOT_W'(gi));
			assign lvl_hit[gi]  = line_smp[gi] && smp_act && trig_ff[gi];
			assign edge_hit[gi] = line_smp[gi] && smp_act && !prev_act_ff[gi]
			                      && !trig_ff[gi];
		end
	endgenerate

	// Set wins over a same-cycle clear
	wire [IRQ_LINES-1:0] nxt_stat = (stat_ff & ~clr_stat) | lvl_hit;
	wire [IRQ_LINES-1:0] nxt_fwd  = edge_hit | (lvl_hit & ~stat_ff);
	wire [IRQ_LINES-1:0] nxt_evt  = (evt_ff & ~clr_evt) | nxt_fwd;

	always_ff @(posedge CLOCK_I) begin
		if (rst) begin
			mode_ff     <= MODE_RESET[3:0];
			trig_ff     <= LINE_RESET;
			stat_ff     <= LINE_RESET;
			prev_act_ff <= LINE_RESET;
			evt_ff      <= LINE_RESET;
			evt_en_ff   <= LINE_RESET;
			fwd_ff      <= LINE_RESET;
		end else begin
			if (we_mode) mode_ff <= nxt_mode;
			if (we_trig) trig_ff <= nxt_trig;
			if (we_evte) evt_en_ff <= nxt_evt_en;
			stat_ff <= nxt_stat;
			evt_ff  <= nxt_evt;
			fwd_ff  <= nxt_fwd;
			prev_act_ff <= (prev_act_ff & ~line_smp) | (line_smp & {IRQ_LINES{smp_act}});
		end
	end

	assign IRQ_FWD_O = fwd_ff;
	assign IRQ_O     = |(evt_ff & evt_en_ff);

	// Read channel
	logic              rvalid_ff;
	logic [1:0]        rresp_ff;
	logic [31:0]       rdata_ff;
	logic              rd_mode_ff;

	assign S_AXI_ARREADY = !rvalid_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;

	wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
	wire [SEL_N-1:0] rsel = reg_sel(S_AXI_ARADDR);
	wire [31:0] rd_mode = {28'h0, mode_ff};
	wire [31:0] rd_trig = {16'h0, trig_ff};
	wire [31:0] rd_stat = {16'h0, stat_ff};
	wire [31:0] rd_evts = {16'h0, evt_ff};
	wire [31:0] rd_evte = {16'h0, evt_en_ff};
	wire [31:0] rd_word = ({32{rsel[SEL_MODE]}} & rd_mode)
	                    | ({32{rsel[SEL_TRIG]}} & rd_trig)
	                    | ({32{rsel[SEL_STAT]}} & rd_stat)
	                    | ({32{rsel[SEL_EVTS]}} & rd_evts)
	                    | ({32{rsel[SEL_EVTE]}} & rd_evte);
	wire rd_ok = |rsel;

	always_ff @(posedge CLOCK_I) begin
		if (rst) begin
			rvalid_ff  <= 1'b0;
			rresp_ff   <= RESP_OKAY;
			rdata_ff   <= 32'h0;
			rd_mode_ff <= 1'b0;
		end else begin
			rvalid_ff <= ar_take || (rvalid_ff && !S_AXI_RREADY);
			if (ar_take) begin
				rdata_ff   <= rd_word;
				rresp_ff   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
				rd_mode_ff <= rsel[SEL_MODE];
			end
		end
	end

	// Checks
	a_mode_rsvd_zero: assert property (@(posedge CLOCK_I) disable iff (rst)
		S_AXI_RVALID && rd_mode_ff |-> S_AXI_RDATA[31:MODE_RSVD_LSB] == 28'h0)
		else $error("mode reserved bits read nonzero");

	a_reset_clears_all: assert property (@(posedge CLOCK_I) disable iff (rst)
		$past(rst) |-> mode_ff == 4'h0 && trig_ff == LINE_RESET && stat_ff == LINE_RESET)
		else $error("reset left state bits set");

	a_edge_fwd_pulse: assert property (@(posedge CLOCK_I) disable iff (rst)
		|edge_hit |=> (IRQ_FWD_O & $past(edge_hit)) == $past(edge_hit)
		&& (stat_ff & $past(edge_hit)) == (stat_ff & $past(edge_hit) & $past(stat_ff)))
		else $error("edge line not forwarded");

	a_level_sets_stat: assert property (@(posedge CLOCK_I) disable iff (rst)
		|lvl_hit |=> (stat_ff & $past(lvl_hit)) == $past(lvl_hit))
		else $error("level line did not latch");

	a_w1c_clears_stat: assert property (@(posedge CLOCK_I) disable iff (rst)
		(|clr_stat) && (clr_stat & lvl_hit) == LINE_RESET
		|=> (stat_ff & $past(clr_stat)) == LINE_RESET)
		else $error("write one did not clear status");

	a_w0_keeps_stat: assert property (@(posedge CLOCK_I) disable iff (rst)
		we_stat |=> (stat_ff & ~$past(clr_stat)) == ($past(stat_ff) & ~$past(clr_stat))
		|| (|$past(lvl_hit)))
		else $error("write zero changed status");

	a_edge_never_stat: assert property (@(posedge CLOCK_I) disable iff (rst)
		(stat_ff & ~$past(stat_ff) & ~$past(trig_ff)) == LINE_RESET)
		else $error("edge line set status");

	a_level_fwd_once: assert property (@(posedge CLOCK_I) disable iff (rst)
		|(lvl_hit & ~stat_ff) |=> |IRQ_FWD_O ##1 (IRQ_FWD_O & $past(stat_ff)) == '0
		|| (|$past(edge_hit)) || (|$past(lvl_hit)))
		else $error("level interrupt not forwarded");

	c_level_latch: cover property (@(posedge CLOCK_I) disable iff (rst)
		|lvl_hit ##1 |stat_ff);

	c_stat_rearm: cover property (@(posedge CLOCK_I) disable iff (rst)
		|(stat_ff & clr_stat) ##[1:200] |lvl_hit);

	c_edge_irq: cover property (@(posedge CLOCK_I) disable iff (rst)
		|edge_hit ##1 IRQ_O);

endmodule : sirqc_top

// ==== sirqc_agent.sv ====
// Downstream agent model sharing the serial interrupt line
`timescale 1ns/1ps
module sirqc_agent (
	input  wire logic        clk_i,     // Bus clock
	input  wire logic        rst_n_i,   // Sync reset, low
	input  wire logic        host_o_i,  // Host drive value
	input  wire logic        host_oe_i, // Host drive enable
	input  wire logic        kick_i,    // Rise asks for a quiet start
	input  wire logic [15:0] act_i,     // Lines to signal
	output logic             line_o     // Wired line level
);
	logic [7:0] run_ff, pos_ff, nxt_pos;
	logic       kick_ff, kdrv_ff, sdrv_ff, busy, nxt_sdrv;
	int         s;
	assign busy   = (host_oe_i && !host_o_i) || kdrv_ff;
	assign line_o = !(busy || sdrv_ff); // Pull-up when nobody pulls low
	// Position from the recovery cycle after a long low run; stops are shorter
	assign nxt_pos = busy ? 8'hFF : (run_ff > 8'h03) ? 8'h01 :
		(pos_ff == 8'hFF) ? 8'hFF : pos_ff + 8'h01;
	always_comb begin
		s = int'(nxt_pos) - 2;
		nxt_sdrv = (s >= 0) && (s % 3 == 0) && (s < 48) && act_i[s / 3];
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			run_ff  <= 8'h00;
			pos_ff  <= 8'hFF;
			sdrv_ff <= 1'b0;
			kick_ff <= 1'b0;
			kdrv_ff <= 1'b0;
		end else begin
			run_ff  <= busy ? run_ff + 8'h01 : 8'h00;
			pos_ff  <= nxt_pos;
			sdrv_ff <= nxt_sdrv;
			kick_ff <= kick_i;
			kdrv_ff <= kick_i && !kick_ff; // One agent clock starts a quiet frame
		end
	end
endmodule : sirqc_agent

// ==== sirqc_top_tb.sv ====
// Self-checking bench for the serial interrupt stream controller
`timescale 1ns/1ps
module sirqc_top_tb;
	import sirqc_pkg::*;
	localparam logic [13:0] A_MODE = {IDX_MODE, 2'h0};
	localparam logic [13:0] A_TRIG = {IDX_TRIG, 2'h0};
	localparam logic [13:0] A_STAT = {IDX_STAT, 2'h0};
	localparam logic [13:0] A_EVS  = {IDX_EVT_STAT, 2'h0};
	localparam logic [13:0] A_EVE  = {IDX_EVT_EN, 2'h0};
	localparam logic [13:0] A_EVC  = {IDX_EVT_CLR, 2'h0};
	logic        clk = 1'b0, rst_n = 1'b0, glob_rst_n = 1'b1, kick = 1'b0;
	logic [13:0] aw_addr = '0, ar_addr = '0;
	logic [31:0] w_data = '0, r_data;
	logic        aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, line, s_o, s_oe, irq, roe, ro;
	logic [1:0]  b_resp, r_resp, rs;
	logic [31:0] rdv;
	logic [15:0] fwd, fwd_seen = '0, act = '0;
	int          miscompares = 0, tests_run = 0, cyc = 0, fwd0_cnt = 0, w, n_low;
	always #12.5 clk = ~clk;
	sirqc_top i_dut (.CLOCK_I(clk), .RESETN_I(rst_n), .GLOBAL_RESET_PIN_N_I(glob_rst_n),
		.S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_vld), .S_AXI_AWREADY(aw_rdy),
		.S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_vld), .S_AXI_WREADY(w_rdy),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld), .S_AXI_BREADY(b_rdy),
		.S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_vld), .S_AXI_ARREADY(ar_rdy),
		.S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld), .S_AXI_RREADY(r_rdy),
		.SIRQ_I(line), .SIRQ_O(s_o), .SIRQ_OE_O(s_oe), .IRQ_FWD_O(fwd), .IRQ_O(irq));
	sirqc_agent i_agent (.clk_i(clk), .rst_n_i(rst_n), .host_o_i(s_o), .host_oe_i(s_oe),
		.kick_i(kick), .act_i(act), .line_o(line));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, wv, bd;
		int   n;
		@(posedge clk);
		aw = 1'b1;
		wv = 1'b1;
		bd = 1'b0;
		n = 0;
		r = 2'h3;
		aw_addr <= a;
		w_data <= d;
		aw_vld <= 1'b1;
		w_vld <= 1'b1;
		b_rdy <= 1'b1;
		while (!bd && n < 50) begin
			@(posedge clk);
			n++;
			if (aw && aw_rdy) begin
				aw = 1'b0;
				aw_vld <= 1'b0;
			end
			if (wv && w_rdy) begin
				wv = 1'b0;
				w_vld <= 1'b0;
			end
			if (b_vld) begin
				bd = 1'b1;
				r = b_resp;
				b_rdy <= 1'b0;
			end
		end
	endtask : wr
	task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		logic av, dn;
		int   n;
		@(posedge clk);
		av = 1'b1;
		dn = 1'b0;
		n = 0;
		ar_addr <= a;
		ar_vld <= 1'b1;
		r_rdy <= 1'b1;
		while (!dn && n < 50) begin
			@(posedge clk);
			n++;
			if (av && ar_rdy) begin
				av = 1'b0;
				ar_vld <= 1'b0;
			end
			if (r_vld) begin
				dn = 1'b1;
				d = r_data;
				r = r_resp;
				r_rdy <= 1'b0;
			end
		end
	endtask : rd
	task automatic wrchk(input logic [13:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : wrchk
	task automatic rdchk(input string nm, input logic [13:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, e, d);
		chk(nm, {30'h0, RESP_OKAY}, {30'h0, r});
	endtask : rdchk
	// Length of the next full low run longer than three clocks on the line and the host drive just after it
	task automatic meas(input logic seen0, output int w, output logic oe, output logic o);
		logic seen;
		seen = seen0;
		w = 0;
		for (int n = 0; n < 400; n++) begin
			@(posedge clk);
			if (!line) begin
				w = seen ? w + 1 : 0;
			end else if (w > 3) begin
				oe = s_oe;
				o = s_o;
				break;
			end else begin
				w = 0;
				seen = 1'b1;
			end
		end
	endtask : meas
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rst_n) begin
			fwd_seen <= fwd_seen | fwd;
			fwd0_cnt <= fwd0_cnt + int'(fwd[0]);
		end
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdchk("mode", A_MODE, 32'h0);
		rdchk("trig", A_TRIG, 32'h0);
		rdchk("stat", A_STAT, 32'h0);
		rd(14'h0004, rdv, rs);
		chk("unmapped rd", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wr(14'h0004, 32'hFFFF_FFFF, rs);
		chk("unmapped wr", {30'h0, RESP_SLVERR}, {30'h0, rs});
		wrchk(A_MODE, 32'h0000_00FF);
		rdchk("mode rsvd", A_MODE, 32'h0000_000F);
		for (int c = 0; c < 3; c++) begin
			wrchk(A_MODE, {28'h0, c[1:0], 1'b0, c[0]});
			meas(1'b0, w, roe, ro);
			chk("start width", 32'(4 + 2 * c), w);
			chk("recovery oe", {31'h0, !c[0]}, {31'h0, roe});
			chk("recovery val", 32'h1, {31'h0, ro});
		end
		wrchk(A_MODE, 32'h0000_0002);
		repeat (120) @(posedge clk);
		n_low = 0;
		repeat (200) begin
			@(posedge clk);
			n_low += int'(s_oe && !s_o);
		end
		chk("quiet idle", 32'h0, n_low);
		kick <= 1'b1;
		meas(1'b1, w, roe, ro);
		kick <= 1'b0;
		chk("quiet start", 32'h4, w);
		wrchk(A_MODE, 32'h0);
		wrchk(A_TRIG, 32'h0000_00F0);
		act <= 16'h00A3;
		repeat (250) @(posedge clk);
		rdchk("stat", A_STAT, 32'h0000_00A0);
		chk("fwd", 32'h0000_00A3, {16'h0, fwd_seen});
		act <= 16'h0003;
		repeat (250) @(posedge clk);
		wrchk(A_STAT, 32'h0000_0020);
		rdchk("stat w1c", A_STAT, 32'h0000_0080);
		wrchk(A_STAT, 32'h0);
		rdchk("stat w0", A_STAT, 32'h0000_0080);
		act <= 16'h00A3;
		repeat (250) @(posedge clk);
		rdchk("stat rearm", A_STAT, 32'h0000_00A0);
		chk("edge once", 32'h1, fwd0_cnt);
		rdchk("evt stat", A_EVS, 32'h0000_00A3);
		chk("irq masked", 32'h0, {31'h0, irq});
		wrchk(A_EVE, 32'h0000_0002);
		@(posedge clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wrchk(A_EVC, 32'h0000_0002);
		@(posedge clk);
		chk("irq clr", 32'h0, {31'h0, irq});
		rdchk("evt stat clr", A_EVS, 32'h0000_00A1);
		rdchk("evt clr", A_EVC, 32'h0);
		wrchk(A_MODE, 32'h0000_0006);
		wrchk(A_TRIG, 32'h0000_FFFF);
		glob_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		glob_rst_n <= 1'b1;
		rdchk("mode glob rst", A_MODE, 32'h0);
		rdchk("trig glob rst", A_TRIG, 32'h0);
		rdchk("stat glob rst", A_STAT, 32'h0);
		print_verdict();
	end
endmodule : sirqc_top_tb
